// ==== core/udsc_top.sv ====
// How it works
// - enable bits 7,5,4: bit stuff, buffer, turnaround timeout errors; 1 enables.
// - enable bits 3..0: non-byte field, crc16, crc5, packet id errors.
// - each descriptor use pushes a status into a four entry queue.
// - up to three further completions queue behind the presented status, never overwrite.
// - clearing token flag advances window; next valid entry re-raises flag.
// - status bits 7..4 give endpoint number 0 to 6.
// - status bit 3 is 1 for in transfer, 0 for out.
// - status bit 2 tells odd or even descriptor bank.
// - setup token sets hold bit 5 and stops packet traffic.
// - engine resumes token processing only after software clears hold bit.
// - wake bit 2 drives resume signaling while set and enable bit 0 is set; software times it.
// - writing 1 to bit 1 clears ping-pong odd bits for endpoints 5,6.
// - ping-pong clear leaves endpoints 0 to 4 untouched.
// - control bit 0 enables the module.
// - setting enable also clears odd bits and resets engine logic.
// - enabled error flags are ored into the main error flag.
// - error flags set on detection, clear by writing one, reset zero.
`default_nettype none
module udsc_top (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // avalon-mm slave
  input wire logic [udsc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  // engine side
  input wire logic [7:0] i_err_detect,
  input wire logic i_token_done,
  input wire logic [3:0] i_token_ep,
  input wire logic i_token_in,
  input wire logic i_token_odd,
  input wire logic i_setup_rx,
  output logic o_engine_run,
  output logic o_engine_reset,
  output logic o_resume_drive,
  output logic [udsc_pkg::NUM_EP-1:0] o_pp_odd,
  output logic o_error_irq,
  output logic o_token_complete_irq,
  output logic o_status_dropped
);
  import udsc_pkg::*;

  // ************************************************************
  // bus decode
  // ************************************************************
  logic ack_q;
  logic acc;
  logic fire;
  logic wr_ok;
  logic rd_ok;
  logic hit_flags;
  logic hit_en;
  logic hit_stat;
  logic hit_ctrl;
  logic hit_main;
  logic mapped;
  logic lane0;

  // one wait state: request answered on the second edge
  assign acc = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  // writes land only on the edge that sees waitrequest low
  assign fire = (i_avs_read || i_avs_write) && ack_q;
  assign lane0 = i_avs_byteenable[0];
  assign hit_flags = (i_avs_address == OFF_ERR_FLAGS);
  assign hit_en = (i_avs_address == OFF_ERR_EN);
  assign hit_stat = (i_avs_address == OFF_STATUS);
  assign hit_ctrl = (i_avs_address == OFF_CTRL);
  assign hit_main = (i_avs_address == OFF_MAIN_IRQ);
  assign mapped = hit_flags || hit_en || hit_stat || hit_ctrl || hit_main;
  assign wr_ok = fire && i_avs_write && lane0;
  assign rd_ok = acc && i_avs_read;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] err_en_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] wdat;
  logic en_rise;
  logic bank_clr;
  logic hold_set;
  logic hold_clr;
  logic tok_clr;
  logic [7:0] flag_clr;

  assign wdat = i_avs_writedata[7:0];
  assign en_rise = wr_ok && hit_ctrl && wdat[CT_ENABLE] && !ctrl_q[CT_ENABLE];
  assign bank_clr = wr_ok && hit_ctrl && wdat[CT_BANK_CLR];
  assign hold_set = i_setup_rx && ctrl_q[CT_ENABLE];
  assign hold_clr = wr_ok && hit_ctrl && !wdat[CT_HOLD];
  assign tok_clr = wr_ok && hit_main && wdat[MI_TOKEN];
  assign flag_clr = (wr_ok && hit_flags) ? wdat : 8'h00;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ok && hit_ctrl) begin
      ctrl_d[CT_ENABLE] = wdat[CT_ENABLE];
      ctrl_d[CT_WAKE] = wdat[CT_WAKE];
    end
    // hold can only be set by the engine; a write of 0 releases it
    if (hold_clr) begin
      ctrl_d[CT_HOLD] = 1'b0;
    end
    if (hold_set) begin
      ctrl_d[CT_HOLD] = 1'b1;
    end
    ctrl_d[CT_BANK_CLR] = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_en_q <= ERR_EN_RST;
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ok && hit_en) begin
        err_en_q <= wdat & ERR_EN_MASK;
      end
      ctrl_q <= ctrl_d;
    end
  end

  // ************************************************************
  // error flags
  // ************************************************************
  logic [7:0] err_flags;
  logic err_any;

  udsc_err_flags #(
    .WIDTH(8)
  ) u_err (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_set(i_err_detect),
    .i_clr(flag_clr),
    .i_en(err_en_q),
    .o_flags(err_flags),
    .o_any(err_any)
  );
  assign o_error_irq = err_any;

  // ************************************************************
  // transaction status queue
  // ************************************************************
  logic [7:0] stat_in;
  logic stat_push;
  logic stat_valid;
  logic stat_full;
  logic [7:0] stat_head;
  logic tok_flag_q;
  logic drop_q;

  always_comb begin
    stat_in = 8'h00;
    stat_in[ST_EP_LSB +: 4] = i_token_ep;
    stat_in[ST_IN] = i_token_in;
    stat_in[ST_ODD] = i_token_odd;
  end
  assign stat_push = i_token_done && ctrl_q[CT_ENABLE];

  udsc_stat_fifo #(
    .WIDTH(8),
    .DEPTH(STAT_DEPTH)
  ) u_stat (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_flush(en_rise),
    .i_push(stat_push),
    .i_data(stat_in),
    .i_pop(tok_clr && tok_flag_q),
    .o_valid(stat_valid),
    .o_full(stat_full),
    .o_head(stat_head)
  );

  // flag mirrors a valid head; after a pop it re-raises next cycle if more wait
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tok_flag_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      tok_flag_q <= tok_clr ? 1'b0 : (stat_valid || stat_push) && !en_rise;
      drop_q <= stat_push && stat_full && !(tok_clr && tok_flag_q);
    end
  end
  assign o_token_complete_irq = tok_flag_q;
  assign o_status_dropped = drop_q;

  // ************************************************************
  // ping-pong bank bits
  // ************************************************************
  logic [NUM_EP-1:0] pp_q;
  genvar e;
  for (e = 0; e < NUM_EP; e++) begin : g_pp
    if (e >= PP_FIRST_EP) begin : g_dbl
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          pp_q[e] <= 1'b0;
        end else if (bank_clr || en_rise) begin
          pp_q[e] <= 1'b0;
        end else if (stat_push && i_token_ep == 4'(e)) begin
          pp_q[e] <= ~i_token_odd;
        end
      end
    end else begin : g_single
      // single-buffered endpoints never flip banks
      assign pp_q[e] = 1'b0;
    end
  end
  assign o_pp_odd = pp_q;

  // ************************************************************
  // engine controls
  // ************************************************************
  logic eng_rst_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eng_rst_q <= 1'b0;
    end else begin
      eng_rst_q <= en_rise;
    end
  end
  assign o_engine_reset = eng_rst_q;
  assign o_engine_run = ctrl_q[CT_ENABLE] && !ctrl_q[CT_HOLD];
  assign o_resume_drive = ctrl_q[CT_WAKE] && ctrl_q[CT_ENABLE];

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] rmux;
  logic [7:0] main_irq;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;

  always_comb begin
    main_irq = 8'h00;
    main_irq[MI_TOKEN] = tok_flag_q;
    main_irq[MI_ERROR] = err_any;
  end
  assign rmux = hit_flags ? err_flags :
                hit_en ? err_en_q :
                hit_stat ? stat_head :
                hit_ctrl ? ctrl_q :
                hit_main ? main_irq : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end else if (acc) begin
      rdata_q <= rd_ok ? {24'h00_0000, rmux} : 32'h0000_0000;
      resp_q <= mapped ? 2'h0 : 2'h3;
    end
  end
  assign o_avs_readdata = rdata_q;
  assign o_avs_response = resp_q;
endmodule : udsc_top
`default_nettype wire

// ==== core/udsc_pkg.sv ====
`default_nettype none
package udsc_pkg;
  // ************************************************************
  // register map, word addresses on the avalon slave
  // ************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_ERR_FLAGS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_ERR_EN = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_MAIN_IRQ = 4'h4;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned EE_BIT_STUFF = 7;
  localparam int unsigned EE_BUFFER = 5;
  localparam int unsigned EE_TURNAROUND = 4;
  localparam int unsigned EE_NON_BYTE = 3;
  localparam int unsigned EE_CRC16 = 2;
  localparam int unsigned EE_CRC5 = 1;
  localparam int unsigned EE_PACKET_ID = 0;
  localparam logic [7:0] ERR_EN_MASK = 8'hBF;
  localparam int unsigned ST_EP_LSB = 4;
  localparam int unsigned ST_IN = 3;
  localparam int unsigned ST_ODD = 2;
  localparam int unsigned CT_HOLD = 5;
  localparam int unsigned CT_WAKE = 2;
  localparam int unsigned CT_BANK_CLR = 1;
  localparam int unsigned CT_ENABLE = 0;
  localparam int unsigned MI_TOKEN = 3;
  localparam int unsigned MI_ERROR = 1;
  // ************************************************************
  // reset values and sizes
  // ************************************************************
  localparam logic [7:0] ERR_FLAGS_RST = 8'h00;
  localparam logic [7:0] ERR_EN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int unsigned STAT_DEPTH = 4;
  localparam int unsigned NUM_EP = 7;
  localparam int unsigned PP_FIRST_EP = 5;
endpackage : udsc_pkg
`default_nettype wire

// ==== core/udsc_err_flags.sv ====
`default_nettype none
module udsc_err_flags #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clr,
  input wire logic [WIDTH-1:0] i_en,
  output logic [WIDTH-1:0] o_flags,
  output logic o_any
);
  import udsc_pkg::*;
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;
  // set beats a same-cycle write-one clear
  assign flags_d = (flags_q & ~i_clr) | i_set;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_q <= WIDTH'(ERR_FLAGS_RST);
    end else begin
      flags_q <= flags_d;
    end
  end
  assign o_flags = flags_q;
  assign o_any = |(flags_q & i_en);
endmodule : udsc_err_flags
`default_nettype wire

// ==== core/udsc_stat_fifo.sv ====
`default_nettype none
module udsc_stat_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic o_valid,
  output logic o_full,
  output logic [WIDTH-1:0] o_head
);
  import udsc_pkg::*;
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] rd_q;
  logic [PW-1:0] wr_q;
  logic [PW:0] cnt_q;
  logic do_pop;
  logic do_push;
  assign o_valid = (cnt_q != '0);
  assign o_full = (cnt_q == (PW+1)'(DEPTH));
  assign do_pop = i_pop && o_valid;
  // a full queue drops the newest status
  assign do_push = i_push && (!o_full || do_pop);
  assign o_head = mem_q[rd_q];
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      rd_q <= do_pop ? PW'(rd_q + 1'b1) : rd_q;
      wr_q <= do_push ? PW'(wr_q + 1'b1) : wr_q;
      cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_slot
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        mem_q[g] <= '0;
      end else if (do_push && (wr_q == PW'(g))) begin
        mem_q[g] <= i_data;
      end
    end
  end
endmodule : udsc_stat_fifo
`default_nettype wire

// ==== bench/udsc_top_props.sv ====
`default_nettype none
module udsc_top_props (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [udsc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic i_token_done,
  input wire logic i_setup_rx,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] o_avs_response,
  input wire logic o_engine_run,
  input wire logic o_engine_reset,
  input wire logic [udsc_pkg::NUM_EP-1:0] o_pp_odd,
  input wire logic o_token_complete_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import udsc_pkg::*;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic wr_done;
  logic ctrl_wr;
  logic pop_wr;
  assign wr_done = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  assign ctrl_wr = wr_done & (i_avs_address == OFF_CTRL);
  assign pop_wr = wr_done & (i_avs_address == OFF_MAIN_IRQ) & i_avs_writedata[MI_TOKEN];
  AST_ONE_WAIT: assert property ((i_avs_read | i_avs_write) & o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("second wait state seen");
  AST_FIRST_WAIT: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
    else $error("request answered without wait state");
  AST_RD_RESP: assert property (i_avs_read & !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0
    && o_avs_response == ((i_avs_address > OFF_MAIN_IRQ) ? 2'h3 : 2'h0))
    else $error("read answer malformed");
  AST_SETUP_HOLD: assert property (i_setup_rx && o_engine_run |-> ##[1:2] !o_engine_run)
    else $error("engine kept running after setup");
  AST_RUN_BY_WRITE: assert property ($rose(o_engine_run) |-> $past(ctrl_wr))
    else $error("engine started without control write");
  AST_LOW_BANKS: assert property (o_pp_odd[PP_FIRST_EP-1:0] == '0)
    else $error("bank bit set on single buffered endpoint");
  AST_POP_DROP: assert property (pop_wr && o_token_complete_irq |=> !o_token_complete_irq)
    else $error("token flag not dropped on clear");
  AST_TOK_KEEP: assert property (o_token_complete_irq && !pop_wr && !ctrl_wr
    |=> o_token_complete_irq) else $error("token flag lost without clear");
  AST_TOK_RISE: assert property (i_token_done && o_engine_run
    |-> ##[1:3] o_token_complete_irq) else $error("token completion not flagged");
  AST_ENRST: assert property (o_engine_reset |=> !o_engine_reset && o_pp_odd == '0)
    else $error("engine reset pulse wrong");
  cover property (pop_wr && o_token_complete_irq);
  cover property (i_setup_rx && o_engine_run);
  cover property (o_engine_reset);
endmodule : udsc_top_props
bind udsc_top udsc_top_props u_udsc_top_props (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .i_token_done(i_token_done), .i_setup_rx(i_setup_rx), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
  .o_engine_run(o_engine_run), .o_engine_reset(o_engine_reset), .o_pp_odd(o_pp_odd),
  .o_token_complete_irq(o_token_complete_irq));
`default_nettype wire

// ==== bench/udsc_engine_model.sv ====
`default_nettype none
module udsc_engine_model (
  input wire logic i_ref_clk,
  input wire logic i_engine_run,
  output logic [7:0] o_err_detect,
  output logic o_token_done,
  output logic [3:0] o_token_ep,
  output logic o_token_in,
  output logic o_token_odd,
  output logic o_setup_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_err_detect = 8'h00;
    o_token_done = 1'h0;
    o_token_ep = 4'hF;
    o_token_in = 1'h1;
    o_token_odd = 1'h1;
    o_setup_rx = 1'h0;
  end
  task automatic send_err(input logic [7:0] e);
    @(posedge i_ref_clk);
    o_err_detect <= e;
    @(posedge i_ref_clk);
    o_err_detect <= 8'h00;
  endtask : send_err
  task automatic token(input logic [3:0] ep, input logic in, input logic odd, input logic last);
    while (!i_engine_run) @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    o_token_done <= 1'h1;
    o_token_ep <= ep;
    o_token_in <= in;
    o_token_odd <= odd;
    if (last) begin
      @(posedge i_ref_clk);
      o_token_done <= 1'h0;
      // sideband is not held past the pulse
      o_token_ep <= ~ep;
      o_token_in <= ~in;
      o_token_odd <= ~odd;
    end
  endtask : token
  task automatic setup();
    @(posedge i_ref_clk);
    o_setup_rx <= 1'h1;
    @(posedge i_ref_clk);
    o_setup_rx <= 1'h0;
  endtask : setup
endmodule : udsc_engine_model
`default_nettype wire

// ==== bench/tb_usb_device_status_control.sv ====
`default_nettype none
module tb_usb_device_status_control;
  timeunit 1ns;
  timeprecision 1ps;
  import udsc_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [1:0] rsp_o;
  logic [7:0] err_det;
  logic tdone, tin, todd, setup, run, erst, resume, err_irq, tok_irq, dropped;
  logic [3:0] tep;
  logic [6:0] pp;
  logic [7:0] rdv;
  logic [1:0] rsp;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int drops = 0;
  int resets = 0;
  udsc_top u_udsc_top (.i_ref_clk(clk), .i_arst_n(arst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_avs_response(rsp_o),
    .i_err_detect(err_det), .i_token_done(tdone), .i_token_ep(tep), .i_token_in(tin),
    .i_token_odd(todd), .i_setup_rx(setup), .o_engine_run(run), .o_engine_reset(erst),
    .o_resume_drive(resume), .o_pp_odd(pp), .o_error_irq(err_irq),
    .o_token_complete_irq(tok_irq), .o_status_dropped(dropped));
  udsc_engine_model u_udsc_engine_model (.i_ref_clk(clk), .i_engine_run(run),
    .o_err_detect(err_det), .o_token_done(tdone), .o_token_ep(tep), .o_token_in(tin),
    .o_token_odd(todd), .o_setup_rx(setup));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (dropped === 1'h1) drops = drops + 1;
    if (erst === 1'h1) resets = resets + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ************************************************************
  // avalon master: held until waitrequest is seen low
  // ************************************************************
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    // request stands until a rising edge samples waitrequest low
    do @(posedge clk); while (wreq !== 1'h0);
    rdv = rdat[7:0];
    rsp = rsp_o;
    chk(rdat[31:8], 24'h0);
    wr <= 1'h0;
    rd <= 1'h0;
  endtask : bus
  task automatic t_regs();
    bus(1'h0, OFF_ERR_FLAGS, 8'h00);
    chk(rdv, ERR_FLAGS_RST);
    bus(1'h0, OFF_ERR_EN, 8'h00);
    chk(rdv, ERR_EN_RST);
    bus(1'h0, OFF_CTRL, 8'h00);
    chk(rdv, CTRL_RST);
    bus(1'h0, 4'hF, 8'h00);
    chk(rsp, 2'h3);
    chk(rdv, 8'h00);
  endtask : t_regs
  task automatic t_errors();
    logic [7:0] m;
    bus(1'h1, OFF_ERR_EN, 8'hFF);
    bus(1'h0, OFF_ERR_EN, 8'h00);
    chk(rdv, ERR_EN_MASK);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) continue;
      m = 8'h01 << i;
      bus(1'h1, OFF_ERR_EN, m);
      u_udsc_engine_model.send_err(~m);
      @(negedge clk);
      chk(err_irq, 1'h0);
      u_udsc_engine_model.send_err(m);
      @(negedge clk);
      chk(err_irq, 1'h1);
      bus(1'h0, OFF_MAIN_IRQ, 8'h00);
      chk(rdv[MI_ERROR], 1'h1);
      bus(1'h0, OFF_ERR_FLAGS, 8'h00);
      chk(rdv & ERR_EN_MASK, ERR_EN_MASK);
      bus(1'h1, OFF_ERR_FLAGS, 8'hFF);
      @(negedge clk);
      chk(err_irq, 1'h0);
    end
  endtask : t_errors
  task automatic t_status();
    logic [3:0] eps [5] = '{4'h0, 4'h6, 4'h5, 4'h3, 4'h2};
    bus(1'h1, OFF_CTRL, 8'h01);
    // five back to back completions into a four deep queue
    for (int i = 0; i < 5; i++) u_udsc_engine_model.token(eps[i], i[0], i[1], i == 4);
    repeat (3) @(negedge clk);
    chk(drops, 1);
    for (int i = 0; i < 4; i++) begin
      chk(tok_irq, 1'h1);
      bus(1'h0, OFF_STATUS, 8'h00);
      chk(rdv[7:2], {eps[i], i[0], i[1]});
      bus(1'h1, OFF_MAIN_IRQ, 8'h08);
      repeat (2) @(negedge clk);
    end
    chk(tok_irq, 1'h0);
    // bank bit points at the bank after the one just used
    chk(pp, 7'h40);
    bus(1'h1, OFF_CTRL, 8'h03);
    @(negedge clk);
    chk(pp, 7'h00);
    bus(1'h0, OFF_CTRL, 8'h00);
    chk(rdv, 8'h01);
  endtask : t_status
  task automatic t_hold();
    u_udsc_engine_model.setup();
    @(negedge clk);
    chk(run, 1'h0);
    bus(1'h0, OFF_CTRL, 8'h00);
    chk(rdv, 8'h21);
    bus(1'h1, OFF_CTRL, 8'h21);
    @(negedge clk);
    chk(run, 1'h0);
    bus(1'h1, OFF_CTRL, 8'h01);
    @(negedge clk);
    chk(run, 1'h1);
    bus(1'h1, OFF_CTRL, 8'h05);
    @(negedge clk);
    chk(resume, 1'h1);
    bus(1'h1, OFF_CTRL, 8'h01);
    @(negedge clk);
    chk(resume, 1'h0);
  endtask : t_hold
  task automatic t_enable();
    // even bank used, so the odd bit of endpoint 5 goes up
    u_udsc_engine_model.token(4'h5, 1'h0, 1'h0, 1'h1);
    repeat (3) @(negedge clk);
    chk(pp, 7'h20);
    bus(1'h1, OFF_CTRL, 8'h00);
    @(negedge clk);
    chk(run, 1'h0);
    bus(1'h1, OFF_CTRL, 8'h01);
    repeat (2) @(negedge clk);
    chk(pp, 7'h00);
    chk(tok_irq, 1'h0);
    chk(resets, 2);
  endtask : t_enable
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    t_regs();
    t_errors();
    t_status();
    t_hold();
    t_enable();
    wrap_up();
  end
endmodule : tb_usb_device_status_control
`default_nettype wire
